// ==== design/lfc_loop_filter.sv ====
// digital loop filter driving the controlled ring oscillator
// assumes comparator grade and its done strobe come from the analog side,
// and osc cycle strobe marks each ring period; single clock ref_clk
//
// Contract
// - control word is divider field over stage field; corrections carry across.
// - step -32,-8,-1,+1,+8,+32 by base clock grade versus nominal.
// - divider values A to F beyond limits act as divider 9.
// - leave out-of-range only by normal negative corrections, no special handling; a +1, +8 or +32 step that passes FFF also leaves it by wrapping to the low words.
// - filter stable flag set when error is within five percent.
// - low five stage bits count long-point cycles out of every 32.
// - coarse 011 gives 23 stages, 25 on dithered cycles.
// - coarse 111 alternates 31 stages with 17 stages divided by two.
// - internal clock is multiply factor times 307.2 kHz base clock.
`default_nettype none
module lfc_loop_filter
	import lfc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic cmpDone,
	input wire logic [2:0] cmpGrade,
	input wire logic oscCycle,
	output logic [WORD_W-1:0] ctrlWord,
	output logic [DIV_W-1:0] oscDividerCtrl,
	output logic [STG_W-1:0] oscStageCtrl,
	output logic outOfRange,
	output logic filterStableFlag,
	output logic useLong,
	output logic [5:0] stageCount,
	output logic divByTwo
);
	////////////////////////////////////////////////////////////////////////
	// reset release and input synchronisers
	logic [1:0] rstSync_ff;
	logic rstN;
	logic doneS1_ff, doneS2_ff, doneS3_ff;
	logic [2:0] gradeS1_ff, gradeS2_ff;
	logic cycS1_ff, cycS2_ff, cycS3_ff;
	logic cmpEvent, cycEvent;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstSync_ff <= 2'b00;
		end else begin
			rstSync_ff <= {rstSync_ff[0], 1'b1};
		end
	end
	assign rstN = rstSync_ff[1];

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			doneS1_ff <= 1'b0;
			doneS2_ff <= 1'b0;
			doneS3_ff <= 1'b0;
			gradeS1_ff <= 3'h0;
			gradeS2_ff <= 3'h0;
			cycS1_ff <= 1'b0;
			cycS2_ff <= 1'b0;
			cycS3_ff <= 1'b0;
		end else begin
			doneS1_ff <= cmpDone;
			doneS2_ff <= doneS1_ff;
			doneS3_ff <= doneS2_ff;
			gradeS1_ff <= cmpGrade;
			gradeS2_ff <= gradeS1_ff;
			cycS1_ff <= oscCycle;
			cycS2_ff <= cycS1_ff;
			cycS3_ff <= cycS2_ff;
		end
	end
	// rising edge: one event per evaluation
	assign cmpEvent = doneS2_ff && !doneS3_ff;
	assign cycEvent = cycS2_ff && !cycS3_ff;

	////////////////////////////////////////////////////////////////////////
	// correction step and control word
	logic [WORD_W-1:0] word_ff, nxt_word;
	logic stable_ff, nxt_stable;
	logic signed [WORD_W-1:0] step;
	lfc_grade_e grade;

	assign grade = lfc_grade_e'(gradeS2_ff);

	always_comb begin
		step = '0;
		unique case (grade)
			GR_BELOW_85: step = -STEP_BIG;
			GR_85_95: step = -STEP_MID;
			GR_95_100: step = -STEP_ONE;
			GR_100_105: step = STEP_ONE;
			GR_105_115: step = STEP_MID;
			GR_ABOVE_115: step = STEP_BIG;
			default: step = '0;
		endcase
	end

	always_comb begin
		nxt_word = word_ff;
		nxt_stable = stable_ff;
		if (cmpEvent) begin
			// full-width add wraps freely past limits; no clamping
			nxt_word = word_ff + step;
			nxt_stable = (grade == GR_95_100) || (grade == GR_100_105);
		end
	end

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			word_ff <= WORD_RST;
			stable_ff <= 1'b0;
		end else begin
			word_ff <= nxt_word;
			stable_ff <= nxt_stable;
		end
	end

	assign ctrlWord = word_ff;
	assign oscStageCtrl = word_ff[STG_W-1:0];
	assign outOfRange = word_ff > WORD_MAX;
	// divider A..F interpreted as the slowest setting
	assign oscDividerCtrl = outOfRange ? DIV_SLOWEST : word_ff[WORD_W-1:STG_W];
	assign filterStableFlag = stable_ff;

	////////////////////////////////////////////////////////////////////////
	// field widths must join into the control word
	if (WORD_W != DIV_W + STG_W) begin : g_badWord
		$error("control word width must equal divider plus stage widths");
	end
	if (STG_W != COARSE_W + FINE_W) begin : g_badStage
		$error("stage field must split into coarse and fine parts");
	end

	////////////////////////////////////////////////////////////////////////
	// fine-adjust dither
	lfc_fine_dither u_dither (
		.ref_clk(ref_clk),
		.rstN(rstN),
		.oscCycle(cycEvent),
		.stageCtrl(word_ff[STG_W-1:0]),
		.useLong(useLong),
		.stageCount(stageCount),
		.divByTwo(divByTwo)
	);

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_oneStep;
		@(posedge ref_clk) disable iff (!rstN)
		!cmpEvent |=> (word_ff == $past(word_ff));
	endproperty
	a_oneStep: assert property (p_oneStep) else $error("word moved without evaluation");
	property p_bigDown;
		@(posedge ref_clk) disable iff (!rstN)
		(cmpEvent && grade == GR_BELOW_85) |=> (word_ff == $past(word_ff) - 12'h020);
	endproperty
	a_bigDown: assert property (p_bigDown) else $error("big down step wrong");
	property p_oneUp;
		@(posedge ref_clk) disable iff (!rstN)
		(cmpEvent && grade == GR_100_105) |=> (word_ff == $past(word_ff) + 12'h001);
	endproperty
	a_oneUp: assert property (p_oneUp) else $error("unit up step wrong");
	property p_slowest;
		@(posedge ref_clk) disable iff (!rstN)
		(word_ff[WORD_W-1:STG_W] > DIV_SLOWEST) |-> (oscDividerCtrl == DIV_SLOWEST);
	endproperty
	a_slowest: assert property (p_slowest) else $error("out-of-range divider not 9");
	property p_stable;
		@(posedge ref_clk) disable iff (!rstN)
		(cmpEvent && (grade == GR_BELOW_85 || grade == GR_ABOVE_115)) |=> !filterStableFlag;
	endproperty
	a_stable: assert property (p_stable) else $error("stable set at large error");
	property p_stableSet;
		@(posedge ref_clk) disable iff (!rstN)
		(cmpEvent && grade == GR_95_100) |=> filterStableFlag;
	endproperty
	a_stableSet: assert property (p_stableSet) else $error("stable not set");
	property p_recover;
		@(posedge ref_clk) disable iff (!rstN)
		(outOfRange && !cmpEvent) |=> outOfRange;
	endproperty
	a_recover: assert property (p_recover) else $error("left range without step");
	property p_mid;
		@(posedge ref_clk) disable iff (!rstN)
		(cmpEvent && grade == GR_105_115) |=> (word_ff == $past(word_ff) + 12'h008);
	endproperty
	a_mid: assert property (p_mid) else $error("mid up step wrong");
	property p_oneDown;
		@(posedge ref_clk) disable iff (!rstN)
		(cmpEvent && grade == GR_95_100) |=> (word_ff == $past(word_ff) - 12'h001);
	endproperty
	a_oneDown: assert property (p_oneDown) else $error("unit down step wrong");
	property p_midDown;
		@(posedge ref_clk) disable iff (!rstN)
		(cmpEvent && grade == GR_85_95) |=> (word_ff == $past(word_ff) - 12'h008);
	endproperty
	a_midDown: assert property (p_midDown) else $error("mid down step wrong");
	property p_bigUp;
		@(posedge ref_clk) disable iff (!rstN)
		(cmpEvent && grade == GR_ABOVE_115) |=> (word_ff == $past(word_ff) + 12'h020);
	endproperty
	a_bigUp: assert property (p_bigUp) else $error("big up step wrong");
	property p_refused;
		@(posedge ref_clk) disable iff (!rstN)
		(cmpEvent && gradeS2_ff > 3'h5) |=> (word_ff == $past(word_ff) && !filterStableFlag);
	endproperty
	a_refused: assert property (p_refused) else $error("unused grade moved word");
	property p_stableUp;
		@(posedge ref_clk) disable iff (!rstN)
		(cmpEvent && grade == GR_100_105) |=> filterStableFlag;
	endproperty
	a_stableUp: assert property (p_stableUp) else $error("stable not set above nominal");
	c_wrap: cover property (@(posedge ref_clk) disable iff (!rstN) outOfRange);
	c_stable: cover property (@(posedge ref_clk) disable iff (!rstN) $rose(filterStableFlag));
	c_carry: cover property (@(posedge ref_clk) disable iff (!rstN)
		cmpEvent ##1 (oscDividerCtrl != $past(oscDividerCtrl)));
endmodule
`default_nettype wire

// ==== common/lfc_pkg.sv ====
// package for the loop filter and ring oscillator control block
// assumes a single clock domain; widths, limits, steps and the 23/25/31/17 stage counts are named here
`default_nettype none
package lfc_pkg;
	localparam int WORD_W = 12;
	localparam int DIV_W = 4;
	localparam int STG_W = 8;
	localparam int FINE_W = 5;
	localparam int COARSE_W = 3;
	localparam logic [WORD_W-1:0] WORD_MAX = 12'h9FF;
	localparam logic [WORD_W-1:0] WORD_RST = 12'h000;
	localparam logic [DIV_W-1:0] DIV_SLOWEST = 4'h9;
	localparam logic signed [WORD_W-1:0] STEP_BIG = 12'sh020;
	localparam logic signed [WORD_W-1:0] STEP_MID = 12'sh008;
	localparam logic signed [WORD_W-1:0] STEP_ONE = 12'sh001;
	localparam logic [COARSE_W-1:0] COARSE_23 = 3'h3;
	localparam logic [COARSE_W-1:0] COARSE_31 = 3'h7;
	localparam logic [5:0] STAGES_23 = 6'h17;
	localparam logic [5:0] STAGES_25 = 6'h19;
	localparam logic [5:0] STAGES_31 = 6'h1F;
	localparam logic [5:0] STAGES_17 = 6'h11;
	localparam int BASE_FREQ_HZ = 307200;
	// comparator grades of base clock vs nominal
	typedef enum logic [2:0] {
		GR_BELOW_85,
		GR_85_95,
		GR_95_100,
		GR_100_105,
		GR_105_115,
		GR_ABOVE_115
	} lfc_grade_e;
endpackage
`default_nettype wire

// ==== design/lfc_fine_dither.sv ====
// fine-adjust dither: picks long or short ring point per oscillator cycle
// assumes oscCycle is a one-cycle enable, one per ring oscillator period
`default_nettype none
module lfc_fine_dither
	import lfc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstN,
	input wire logic oscCycle,
	input wire logic [STG_W-1:0] stageCtrl,
	output logic useLong,
	output logic [5:0] stageCount,
	output logic divByTwo
);
	logic [FINE_W-1:0] phase_ff;
	logic [FINE_W-1:0] nxt_phase;
	logic [COARSE_W-1:0] coarse;

	assign coarse = stageCtrl[STG_W-1:FINE_W];

	always_comb begin
		nxt_phase = phase_ff;
		if (oscCycle) begin
			nxt_phase = phase_ff + 5'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			phase_ff <= 5'h00;
		end else begin
			phase_ff <= nxt_phase;
		end
	end

	// long point for fine-field cycles out of every 32
	assign useLong = phase_ff < stageCtrl[FINE_W-1:0];

	always_comb begin
		stageCount = STAGES_23;
		divByTwo = 1'b0;
		if (coarse == COARSE_31) begin
			stageCount = useLong ? STAGES_17 : STAGES_31;
			divByTwo = useLong;
		end else if (coarse == COARSE_23) begin
			stageCount = useLong ? STAGES_25 : STAGES_23;
		end else begin
			stageCount = {3'h0, coarse} + 6'h10 + (useLong ? 6'h02 : 6'h00);
		end
	end

	property p_zeroShort;
		@(posedge ref_clk) disable iff (!rstN)
		(stageCtrl[FINE_W-1:0] == 5'h00) |-> !useLong;
	endproperty
	a_zeroShort: assert property (p_zeroShort) else $error("fine zero must keep short point");
	property p_ring23;
		@(posedge ref_clk) disable iff (!rstN)
		(coarse == COARSE_23) |-> (stageCount == (useLong ? STAGES_25 : STAGES_23));
	endproperty
	a_ring23: assert property (p_ring23) else $error("ring stage count wrong");
	property p_ring31;
		@(posedge ref_clk) disable iff (!rstN)
		(coarse == COARSE_31 && useLong) |-> (divByTwo && stageCount == STAGES_17);
	endproperty
	a_ring31: assert property (p_ring31) else $error("divided ring setting wrong");
	c_long: cover property (@(posedge ref_clk) disable iff (!rstN) useLong && divByTwo);
endmodule
`default_nettype wire

// ==== test/lfc_comparator_model.sv ====
// frequency comparator and ring oscillator model facing the loop filter
// assumes evaluate() is called only once reset has been released
`default_nettype none
module lfc_comparator_model (
	input wire logic ref_clk,
	output logic cmpDone,
	output logic [2:0] cmpGrade,
	output logic oscCycle
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		cmpDone = 1'b0;
		cmpGrade = 3'h0;
		oscCycle = 1'b0;
	end
	// ring period runs free, unrelated in phase to ref_clk
	always #23 oscCycle = ~oscCycle;
	////////////////////////////////////////////////////////////////
	// one evaluation; slow stretches both the high and the low phase
	task automatic evaluate(input logic [2:0] grade, input bit slow);
		@(posedge ref_clk);
		#1;
		cmpGrade = grade;
		cmpDone = 1'b1;
		repeat (slow ? 3 : 2) @(posedge ref_clk);
		#1;
		cmpDone = 1'b0;
		// grade is not held once the evaluation is over
		cmpGrade = ~grade;
		repeat (slow ? 4 : 2) @(posedge ref_clk);
	endtask
endmodule
`default_nettype wire

// ==== test/lfc_loop_filter_bench.sv ====
// self-checking bench for the loop filter and ring oscillator control
// assumes the comparator model drives the analog side; one clock domain
`default_nettype none
module lfc_loop_filter_bench
	import lfc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic cmpDone;
	logic oscCycle;
	logic [2:0] cmpGrade;
	logic [WORD_W-1:0] ctrlWord;
	logic [DIV_W-1:0] oscDividerCtrl;
	logic [STG_W-1:0] oscStageCtrl;
	logic outOfRange;
	logic filterStableFlag;
	logic useLong;
	logic [5:0] stageCount;
	logic divByTwo;
	int mismatches = 0;
	int checksDone = 0;
	logic monitorOn = 1'b1;
	int longCount = 0;
	logic [WORD_W-1:0] expWord = WORD_RST;
	logic [12:0] noteQ[$];
	logic [WORD_W-1:0] stepTab[8] = '{12'hFE0, 12'hFF8, 12'hFFF, 12'h001, 12'h008, 12'h020,
		12'h000, 12'h000};
	always #5 ref_clk = ~ref_clk;
	lfc_loop_filter lfc_loop_filter_inst (.ref_clk(ref_clk), .arst_n(arst_n),
		.cmpDone(cmpDone), .cmpGrade(cmpGrade), .oscCycle(oscCycle), .ctrlWord(ctrlWord),
		.oscDividerCtrl(oscDividerCtrl), .oscStageCtrl(oscStageCtrl), .outOfRange(outOfRange),
		.filterStableFlag(filterStableFlag), .useLong(useLong), .stageCount(stageCount),
		.divByTwo(divByTwo));
	lfc_comparator_model lfc_comparator_model_inst (.ref_clk(ref_clk), .cmpDone(cmpDone),
		.cmpGrade(cmpGrade), .oscCycle(oscCycle));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
		checksDone++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic testDone();
		$display("checks %0d mismatches %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// note the expected word and flag, then run one evaluation
	task automatic evalOne(input logic [2:0] g);
		expWord = expWord + stepTab[g];
		noteQ.push_back({(g == 3'h2 || g == 3'h3), expWord});
		lfc_comparator_model_inst.evaluate(g, $urandom_range(1, 0) == 1);
	endtask
	////////////////////////////////////////////////////////////////
	// result lands two edges after the first edge that sees the rise
	initial begin
		logic [12:0] note;
		forever begin
			@(posedge cmpDone);
			repeat (4) @(posedge ref_clk);
			#2;
			note = noteQ.pop_front();
			check(ctrlWord, note[11:0]);
			check({4'h0, oscStageCtrl}, {4'h0, note[7:0]});
			check({11'h000, filterStableFlag}, {11'h000, note[12]});
			check({11'h000, outOfRange}, {11'h000, note[11:0] > WORD_MAX});
			check({8'h00, oscDividerCtrl},
				{8'h00, note[11:0] > WORD_MAX ? DIV_SLOWEST : note[11:8]});
			if (note[7:5] == COARSE_23)
				check({6'h00, stageCount}, {6'h00, useLong ? STAGES_25 : STAGES_23});
			if (note[7:5] == COARSE_31)
				check({5'h00, divByTwo, stageCount},
					{5'h00, useLong, useLong ? STAGES_17 : STAGES_31});
			if (note[4:0] == 5'h00)
				check({11'h000, useLong}, 12'h000);
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h2833));
		repeat (3) @(posedge ref_clk);
		#1;
		arst_n = 1'b1;
		repeat (4) @(posedge ref_clk);
		#2;
		check(ctrlWord, WORD_RST);
		check({11'h000, filterStableFlag}, 12'h000);
		$display("test reset done");
		for (int g = 0; g < 8; g++)
			evalOne(3'(g));
		$display("test grades done");
		// one step below zero, then back
		evalOne(3'h2);
		evalOne(3'h3);
		// climb past the upper limit, then return by ordinary negative steps
		repeat (82) evalOne(3'h5);
		repeat (4) evalOne(3'h0);
		$display("test range done");
		// factor change: monitorOn cleared first, then loaded from the stable flag and checked set; the monitor ignores it
		monitorOn = 1'b0;
		evalOne(3'h5);
		repeat (3) evalOne(3'h0);
		evalOne(3'h2);
		@(negedge ref_clk);
		monitorOn = filterStableFlag;
		check({11'h000, monitorOn}, 12'h001);
		$display("test factor done");
		repeat (300) evalOne(3'($urandom_range(7, 0)));
		$display("test random done");
		// steady word: long point must be used fine-field times in 32 ring periods
		longCount = 0;
		@(posedge oscCycle);
		repeat (32) begin
			@(posedge oscCycle);
			#1;
			if (useLong)
				longCount++;
		end
		check(12'(longCount), {7'h00, expWord[4:0]});
		$display("test dither done");
		repeat (8) @(posedge ref_clk);
		testDone();
	end
	initial begin
		#400000;
		mismatches++;
		$display("ERROR %0t ns: watchdog expired", $time);
		testDone();
	end
endmodule
`default_nettype wire
